// [hdl/epp_core.sv]
//********************************************************************
// epp_core: serial command front end with protection and erase control
//********************************************************************
// Purpose: latch, status register, protection, erase and power-down
// Assumes: serial pins sampled on clk through two-stage synchronisers
// Notes:   array storage is outside; erase requests leave as strobes
// Functional notes
// RULE1: set-latch command sets latch, clear-latch clears; no write completes without it
// RULE2: latch clears at reset and after each completed clear, status write or erase
// RULE3: host sends set-latch first and raises select after eight bits
// RULE4: status read is answered at any time, even while busy; code does not answer it while asleep
// RULE5: status layout: protect enable 7, block bits 3 and 2, latch 1, busy 0
// RULE6: busy bit reads one during a self-timed cycle, zero otherwise
// RULE7: latch bit mirrors the latch; set and clear always update it; code ignores both while busy or asleep
// RULE8: block and protect-enable bits are kept and changed only by status write
// RULE9: block code 01 guards C000h up, 10 guards 8000h up, 11 guards all
// RULE10: hardware protection on only when protect pin low and enable bit one
// RULE11: hardware protection blocks only status writes, not array writes
// RULE12: latch clear rejects all writes; latch set follows block and hardware protection
// RULE13: page erase with two address bytes erases the addressed page to FFh
// RULE14: page erase starts only when select rises right after last address bit
// RULE15: page erase to a protected block is aborted
// RULE16: sector erase with address starts only on select rise after address
// RULE17: sector erase to a protected sector is aborted
// RULE18: chip erase is opcode only; starts on select rise after eighth bit
// RULE19: chip erase ignored whenever any block-protect bit is set
// RULE20: deep sleep entered only on select rise right after eighth bit
// RULE21: while asleep only signature-release is obeyed; it wakes after a delay
// RULE22: reset always comes up in standby
// RULE23: opcodes 06h set the latch and 04h clear it
// RULE24: opcodes 42h page erase, D8h sector erase, C7h chip erase
// RULE25: all bytes most significant bit first, sampled on rising serial clock
// RULE26: status write takes one data byte, then a self-timed busy cycle
module epp_core
(
	// system
	input  wire logic        clk,
	input  wire logic        nrst,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        si,
	output logic             so,
	output logic             so_oe_n,
	input  wire logic        wp_n,
	// nonvolatile status image, loaded at power-up
	input  wire logic [2:0]  nv_init,
	// erase requests to the array
	output logic             erase_req,
	output logic [2:0]       erase_kind,
	output logic [15:0]      erase_addr,
	// state views
	output logic             asleep,
	output logic [7:0]       protection_status
);
	//****************************************************************
	// pin synchronisers
	//****************************************************************
	logic [2:0] cs_sync_reg;
	logic [2:0] sck_sync_reg;
	logic [1:0] si_sync_reg;
	logic [1:0] wp_sync_reg;
	logic       cs_n_s;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       cs_fall;

	// third stage only feeds edge detection, never the first
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_sync_reg  <= 3'h7;
			sck_sync_reg <= 3'h0;
			si_sync_reg  <= 2'h0;
			wp_sync_reg  <= 2'h3;
		end
		else
		begin
			cs_sync_reg  <= {cs_sync_reg[1:0], cs_n};
			sck_sync_reg <= {sck_sync_reg[1:0], sck};
			si_sync_reg  <= {si_sync_reg[0], si};
			wp_sync_reg  <= {wp_sync_reg[0], wp_n};
		end
	end

	assign cs_n_s   = cs_sync_reg[1];
	assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
	assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
	assign cs_rise  = cs_sync_reg[1] & ~cs_sync_reg[2];
	assign cs_fall  = ~cs_sync_reg[1] & cs_sync_reg[2];

	//****************************************************************
	// serial shifter
	//****************************************************************
	logic [5:0]  bit_cnt_reg;
	logic [23:0] shift_reg;
	logic [7:0]  opcode_reg;

	// msb first, sampled on rising serial clock [RULE25]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_cnt_reg <= 6'h00;
			shift_reg   <= 24'h000000;
			opcode_reg  <= 8'h00;
		end
		else if (cs_fall)
		begin
			bit_cnt_reg <= 6'h00;
		end
		else if (!cs_n_s && sck_rise)
		begin
			shift_reg <= {shift_reg[22:0], si_sync_reg[1]};
			if (bit_cnt_reg != 6'h3F)
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			if (bit_cnt_reg == epp_pkg::BITS_OPCODE - 6'h01)
				opcode_reg <= {shift_reg[6:0], si_sync_reg[1]};
		end
	end

	//****************************************************************
	// status and protection
	//****************************************************************
	logic        latch_reg;
	logic        hw_protect_enable_reg;
	logic [1:0]  block_protect_reg;
	logic        in_progress_flag;
	logic        hw_protected;
	logic        latch_flag;
	logic [15:0] frame_addr;

	// true when the block code guards this address [RULE9]
	function automatic logic addr_guarded(input logic [1:0] bp, input logic [15:0] a);
		unique case (bp)
			2'h0: addr_guarded = 1'b0;
			2'h1: addr_guarded = (a >= epp_pkg::PROT_QUARTER);
			2'h2: addr_guarded = (a >= epp_pkg::PROT_HALF);
			2'h3: addr_guarded = 1'b1;
		endcase
	endfunction

	assign hw_protected = ~wp_sync_reg[1] & hw_protect_enable_reg; // [RULE10]
	assign latch_flag   = latch_reg;                               // [RULE7]
	assign frame_addr   = shift_reg[15:0];
	// layout of the status byte [RULE5]
	always_comb
	begin
		protection_status                    = 8'h00;
		protection_status[epp_pkg::ST_HWPEN] = hw_protect_enable_reg;
		protection_status[epp_pkg::ST_BPH]   = block_protect_reg[1];
		protection_status[epp_pkg::ST_BPL]   = block_protect_reg[0];
		protection_status[epp_pkg::ST_LATCH] = latch_flag;
		protection_status[epp_pkg::ST_BUSY]  = in_progress_flag; // [RULE6]
	end

	//****************************************************************
	// frame-end decode
	//****************************************************************
	logic awake;
	logic go_set, go_clr, go_stat, go_page, go_sect, go_chip, go_sleep, go_wake;

	// a command other than release counts only if select rises right after its last bit
	assign awake    = ~asleep & ~in_progress_flag;
	assign go_set   = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_OPCODE)
			& (opcode_reg == epp_pkg::OP_SET_LATCH);  // [RULE23] [RULE3]
	assign go_clr   = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_OPCODE)
			& (opcode_reg == epp_pkg::OP_CLR_LATCH);  // [RULE23]
	// status write needs latch and no hardware guard [RULE11] [RULE12] [RULE26]
	assign go_stat  = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_DATA)
			& (opcode_reg == epp_pkg::OP_STAT_WRITE) & latch_reg & ~hw_protected;
	// page erase at end of address, unguarded only [RULE14] [RULE15] [RULE24]
	assign go_page  = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_ADDR) & latch_reg
			& (opcode_reg == epp_pkg::OP_PAGE_ERASE)
			& ~addr_guarded(block_protect_reg, frame_addr);
	// sector erase likewise [RULE16] [RULE17]
	assign go_sect  = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_ADDR) & latch_reg
			& (opcode_reg == epp_pkg::OP_SECT_ERASE)
			& ~addr_guarded(block_protect_reg, frame_addr);
	// chip erase opcode only, refused under any block code [RULE18] [RULE19]
	assign go_chip  = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_OPCODE) & latch_reg
			& (opcode_reg == epp_pkg::OP_CHIP_ERASE) & (block_protect_reg == 2'h0);
	assign go_sleep = cs_rise & awake & (bit_cnt_reg == epp_pkg::BITS_OPCODE)
			& (opcode_reg == epp_pkg::OP_DEEP_SLEEP);  // [RULE20]
	// release needs only the opcode, even if select rises late [RULE21]
	assign go_wake  = cs_rise & asleep & (bit_cnt_reg >= epp_pkg::BITS_OPCODE)
			& (opcode_reg == epp_pkg::OP_SIG_RELEASE);

	//****************************************************************
	// write-enable latch
	//****************************************************************
	// resets clear, completed cycles clear [RULE1] [RULE2] [RULE7]
	logic job_done;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			latch_reg <= 1'b0;
		else if (go_set)
			latch_reg <= 1'b1;
		else if (go_clr || job_done)
			latch_reg <= 1'b0;
	end

	//****************************************************************
	// self-timed cycle control
	//****************************************************************
	logic [16:0] job_cnt_reg;
	logic        job_is_stat_reg;
	logic [2:0]  pend_stat_reg;
	logic        nv_loaded_reg;

	assign in_progress_flag = (job_cnt_reg != 17'h00000); // [RULE6]
	assign job_done         = (job_cnt_reg == 17'h00001);

	// counts down the active cycle, busy ends on the last count [RULE13]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			job_cnt_reg     <= 17'h00000;
			job_is_stat_reg <= 1'b0;
			pend_stat_reg   <= 3'h0;
		end
		else if (go_page)
			job_cnt_reg <= 17'(epp_pkg::PAGE_ERASE_CYC);
		else if (go_sect)
			job_cnt_reg <= 17'(epp_pkg::SECT_ERASE_CYC);
		else if (go_chip)
			job_cnt_reg <= 17'(epp_pkg::CHIP_ERASE_CYC);
		else if (go_stat)
		begin
			job_cnt_reg     <= 17'(epp_pkg::STAT_WRITE_CYC);
			job_is_stat_reg <= 1'b1;
			pend_stat_reg   <= {shift_reg[epp_pkg::ST_HWPEN],
				shift_reg[epp_pkg::ST_BPH], shift_reg[epp_pkg::ST_BPL]};
		end
		else if (in_progress_flag)
		begin
			job_cnt_reg <= job_cnt_reg - 17'h00001;
			if (job_done)
				job_is_stat_reg <= 1'b0;
		end
	end

	// nonvolatile bits: image taken after reset, changed only by status write [RULE8]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			nv_loaded_reg         <= 1'b0;
			hw_protect_enable_reg <= 1'b0;
			block_protect_reg     <= 2'h0;
		end
		else if (!nv_loaded_reg)
		begin
			nv_loaded_reg         <= 1'b1;
			hw_protect_enable_reg <= nv_init[2];
			block_protect_reg     <= nv_init[1:0];
		end
		else if (job_done && job_is_stat_reg)
		begin
			hw_protect_enable_reg <= pend_stat_reg[2];
			block_protect_reg     <= pend_stat_reg[1:0];
		end
	end

	// erase strobe to the array, address held until the next request [RULE13] [RULE16] [RULE18]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			erase_req  <= 1'b0;
			erase_kind <= 3'h0;
			erase_addr <= 16'h0000;
		end
		else
		begin
			erase_req <= go_page | go_sect | go_chip;
			if (go_page)
				erase_kind <= epp_pkg::EPP_JOB_PAGE;
			else if (go_sect)
				erase_kind <= epp_pkg::EPP_JOB_SECT;
			else if (go_chip)
				erase_kind <= epp_pkg::EPP_JOB_CHIP;
			if (go_page || go_sect)
				erase_addr <= frame_addr;
			else if (go_chip)
				erase_addr <= 16'h0000;
		end
	end

	//****************************************************************
	// power state
	//****************************************************************
	epp_pkg::epp_pwr_t pwr_reg;
	logic [9:0]        pwr_cnt_reg;
	logic              waking_reg;

	// reset lands in standby [RULE22]; wake delay runs before commands [RULE21]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwr_reg     <= epp_pkg::EPP_PWR_STANDBY;
			pwr_cnt_reg <= 10'h000;
			waking_reg  <= 1'b0;
		end
		else
		begin
			unique case (pwr_reg)
				epp_pkg::EPP_PWR_STANDBY:
				begin
					if (pwr_cnt_reg != 10'h000)
						pwr_cnt_reg <= pwr_cnt_reg - 10'h001;
					else
						waking_reg <= 1'b0;
					if (go_sleep)
					begin
						pwr_reg     <= epp_pkg::EPP_PWR_ENTERING;
						pwr_cnt_reg <= 10'(epp_pkg::SLEEP_ENTRY_CYC);
					end
				end
				epp_pkg::EPP_PWR_ENTERING:
				begin
					if (pwr_cnt_reg != 10'h000)
						pwr_cnt_reg <= pwr_cnt_reg - 10'h001;
					else
						pwr_reg <= epp_pkg::EPP_PWR_ASLEEP;
				end
				epp_pkg::EPP_PWR_ASLEEP:
				begin
					if (go_wake)
					begin
						pwr_reg     <= epp_pkg::EPP_PWR_STANDBY;
						pwr_cnt_reg <= 10'(epp_pkg::WAKE_CYC);
						waking_reg  <= 1'b1;
					end
				end
			endcase
		end
	end

	// commands are refused from sleep entry until the wake delay ends
	assign asleep = (pwr_reg != epp_pkg::EPP_PWR_STANDBY) | waking_reg;

	//****************************************************************
	// serial output
	//****************************************************************
	logic [7:0] out_byte_reg;
	logic       out_en_reg;

	// status may be read mid-cycle, so busy never gates it [RULE4]
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_byte_reg <= 8'h00;
			out_en_reg   <= 1'b0;
		end
		else if (cs_n_s)
			out_en_reg <= 1'b0;
		else if (sck_fall)
		begin
			if (bit_cnt_reg == epp_pkg::BITS_OPCODE && !asleep
				&& opcode_reg == epp_pkg::OP_STAT_READ)
			begin
				out_byte_reg <= protection_status;
				out_en_reg   <= 1'b1;
			end
			else if (bit_cnt_reg[2:0] == 3'h0 && bit_cnt_reg >= epp_pkg::BITS_ADDR
				&& opcode_reg == epp_pkg::OP_SIG_RELEASE && !in_progress_flag)
			begin
				out_byte_reg <= epp_pkg::SIGNATURE;
				out_en_reg   <= 1'b1;
			end
			else if (out_en_reg && bit_cnt_reg[2:0] == 3'h0
				&& opcode_reg == epp_pkg::OP_STAT_READ)
				out_byte_reg <= protection_status;  // repeats while clocked
			else
				out_byte_reg <= {out_byte_reg[6:0], out_byte_reg[7]};
		end
	end

	assign so      = out_byte_reg[7];
	assign so_oe_n = ~out_en_reg;
endmodule

// [hdl/epp_pkg.sv]
//********************************************************************
// epp_pkg: shared constants of the protect/erase/power command logic
//********************************************************************
// Purpose: opcodes, status layout, protection ranges and timing counts
// Assumes: 10 MHz system clock
// Notes:   timing figures are plain defaults, not device limits
package epp_pkg;
	// opcodes
	localparam logic [7:0] OP_SET_LATCH   = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
	localparam logic [7:0] OP_STAT_READ   = 8'h05;
	localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
	localparam logic [7:0] OP_PAGE_ERASE  = 8'h42;
	localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE  = 8'hC7;
	localparam logic [7:0] OP_SIG_RELEASE = 8'hAB;
	localparam logic [7:0] OP_DEEP_SLEEP  = 8'hB9;
	// status bit positions
	localparam int ST_HWPEN = 7;
	localparam int ST_BPH   = 3;
	localparam int ST_BPL   = 2;
	localparam int ST_LATCH = 1;
	localparam int ST_BUSY  = 0;
	// protection boundaries
	localparam logic [15:0] PROT_QUARTER = 16'hC000;
	localparam logic [15:0] PROT_HALF    = 16'h8000;
	// bit counts of a frame
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_ADDR   = 6'h18;
	localparam logic [5:0] BITS_DATA   = 6'h10;
	// timing in microseconds, converted at 10 MHz
	localparam int CLK_MHZ            = 10;
	localparam int PAGE_ERASE_US      = 5000;
	localparam int SECT_ERASE_US      = 10000;
	localparam int CHIP_ERASE_US      = 10000;
	localparam int STAT_WRITE_US      = 5000;
	localparam int SLEEP_ENTRY_DLY_US = 3;
	localparam int WAKE_DLY_US        = 100;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
	localparam int SECT_ERASE_CYC = SECT_ERASE_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
	localparam int STAT_WRITE_CYC = STAT_WRITE_US * CLK_MHZ;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DLY_US * CLK_MHZ;
	localparam int WAKE_CYC        = WAKE_DLY_US * CLK_MHZ;
	// signature byte, value arbitrary
	localparam logic [7:0] SIGNATURE = 8'h5A;
	// power states
	typedef enum logic [2:0]
	{
		EPP_PWR_STANDBY  = 3'b001,
		EPP_PWR_ENTERING = 3'b010,
		EPP_PWR_ASLEEP   = 3'b100
	} epp_pwr_t;
	// self-timed job kinds
	typedef enum logic [2:0]
	{
		EPP_JOB_PAGE  = 3'b001,
		EPP_JOB_SECT  = 3'b010,
		EPP_JOB_CHIP  = 3'b100
	} epp_job_t;
endpackage

// [tb/epp_core_properties.sv]
//********************************************************************
// epp_core_properties: port-level checks of latch, erase and sleep
//********************************************************************
// Purpose: concurrent checks on the command logic outputs
// Assumes: one clock domain, async active-low reset
// Notes:   sees only the ports of epp_core; bound below
module epp_core_properties
(
	// system
	input  wire logic        clk,
	input  wire logic        nrst,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        so_oe_n,
	// erase requests and views
	input  wire logic        erase_req,
	input  wire logic [2:0]  erase_kind,
	input  wire logic [15:0] erase_addr,
	input  wire logic        asleep,
	input  wire logic [7:0]  protection_status
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// a start is one pulse, then the busy flag must hold
	sequence req_pulse;
		erase_req ##1 !erase_req;
	endsequence
	sequence busy_hold;
		protection_status[0] [*8];
	endsequence

	a_req_single_pulse: assert property (erase_req |-> req_pulse)
		else $error("erase start not a single pulse");
	a_busy_after_req: assert property (req_pulse |-> busy_hold)
		else $error("busy flag dropped right after an erase start");
	a_req_needs_latch: assert property (erase_req |-> $past(protection_status[1]))
		else $error("erase started with latch clear");
	a_req_after_select: assert property (erase_req |-> cs_n)
		else $error("erase started while selected");
	a_kind_one_hot: assert property (erase_req |-> $onehot(erase_kind))
		else $error("erase kind not one-hot");
	a_chip_unguarded: assert property ((erase_req && erase_kind == 3'b100) |->
		(protection_status[3:2] == 2'b00 && erase_addr == 16'h0000))
		else $error("chip erase started with block code set");
	a_block_guard: assert property (erase_req |-> !(protection_status[3:2] == 2'b11
		|| (protection_status[3:2] == 2'b10 && erase_addr[15])
		|| (protection_status[3:2] == 2'b01 && erase_addr[15:14] == 2'b11)))
		else $error("erase started in a guarded block");
	a_unused_zero: assert property (protection_status[6:4] == 3'b000)
		else $error("unused status bits not zero");
	a_busy_needs_latch: assert property ($rose(protection_status[0]) |->
		protection_status[1])
		else $error("self-timed cycle began without latch");
	a_latch_drops_done: assert property ($fell(protection_status[0]) |->
		!protection_status[1])
		else $error("latch still set after cycle end");
	a_sleep_no_req: assert property (asleep |-> !erase_req)
		else $error("erase started while asleep");
	a_oe_off_idle: assert property (cs_n [*6] |-> so_oe_n)
		else $error("serial out driven while deselected");
endmodule

bind epp_core epp_core_properties epp_core_properties_i
(
	.clk               (clk),
	.nrst              (nrst),
	.cs_n              (cs_n),
	.so_oe_n           (so_oe_n),
	.erase_req         (erase_req),
	.erase_kind        (erase_kind),
	.erase_addr        (erase_addr),
	.asleep            (asleep),
	.protection_status (protection_status)
);

// [tb/epp_host_model.sv]
//********************************************************************
// epp_host_model: serial host that frames commands for the device
//********************************************************************
// Purpose: drive select, serial clock and data; capture serial out
// Assumes: half period of 5 clk, slow enough for the synchronisers
// Notes:   serial clock stands low between frames
module epp_host_model
(
	// system
	input  wire logic clk,
	// serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// every change lands just after a clk edge
	task automatic half();
		repeat (5) @(posedge clk);
		#1;
	endtask

	// msb first out, then n_rx bits captured before each rise
	task automatic frame(input logic [31:0] tx, input int n_tx, input int n_rx,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		half();
		cs_n = 1'b0;
		for (i = n_tx - 1; i >= 0; i--)
		begin
			si = tx[i];
			half();
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		for (i = 0; i < n_rx; i++)
		begin
			si = ~si;
			half();
			rx = {rx[6:0], so};
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		half();
		cs_n = 1'b1;
		si = ~si; // released line must not look stable
		half();
		half();
	endtask
endmodule

// [tb/epp_core_tb.sv]
//********************************************************************
// epp_core_tb: command sequences against the protect/erase logic
//********************************************************************
// Purpose: latch, status, guard, erase and sleep checks
// Assumes: 10 MHz clock; nv bits loaded from nv_init at reset
// Notes:   one status write runs to completion, the long erases do not
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module epp_core_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        nrst;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        so;
	logic        so_oe_n;
	logic        wp_n;
	logic [2:0]  nv_init;
	logic        erase_req;
	logic [2:0]  erase_kind;
	logic [15:0] erase_addr;
	logic        asleep;
	logic [7:0]  protection_status;
	logic [7:0]  rx;
	int          fails;
	int          n_checks;
	int          n_req;

	epp_core epp_core_i (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
		.so_oe_n(so_oe_n), .wp_n(wp_n), .nv_init(nv_init), .erase_req(erase_req),
		.erase_kind(erase_kind), .erase_addr(erase_addr), .asleep(asleep),
		.protection_status(protection_status));
	// an undriven serial out shows the inverse, so a missing enable garbles the byte
	epp_host_model epp_host_model_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so_oe_n ? ~so : so));

	// clock and start counter
	always #50 clk = ~clk;
	// an unknown strobe counts as a start, so zero-start checks catch it
	always @(posedge clk)
		if (erase_req !== 1'b0)
			n_req++;

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// reset reloads the nonvolatile image, so it stands in for a power cycle
	task automatic do_reset(input logic [2:0] nv);
		nrst = 1'b0;
		nv_init = nv;
		tick(2);
		nrst = 1'b1;
		tick(6);
		n_req = 0;
	endtask

	task automatic cmd(input logic [31:0] tx, input int n);
		epp_host_model_i.frame(tx, n, 0, rx);
	endtask

	task automatic status_chk(input logic [7:0] exp);
		epp_host_model_i.frame(32'h05, 8, 8, rx);
		`CHK("status serial", exp, rx)
		`CHK("status view", exp, protection_status)
		`CHK("serial out released", 1'b1, so_oe_n)
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// watchdog: the status write alone takes 50000 cycles
	initial
	begin
		tick(80000);
		fails++;
		$display("mismatch watchdog expected done seen hang");
		complete_run();
	end

	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		wp_n = 1'b1;
		nv_init = 3'b000;
		fails = 0;
		n_checks = 0;
		do_reset(3'b110);
		status_chk(8'h88);
		cmd(32'h00C, 9);
		status_chk(8'h88);
		cmd(32'h06, 8);
		status_chk(8'h8A);
		cmd(32'h04, 8);
		status_chk(8'h88);
		wp_n = 1'b0;
		cmd(32'h06, 8);
		cmd(32'h0100, 16);
		status_chk(8'h8A);
		// page erase under hardware guard: latch, block guard, framing, good one
		do_reset(3'b101);
		cmd(32'h421234, 24);
		`CHK("page start, latch clear", 0, n_req)
		cmd(32'h06, 8);
		cmd(32'h42C123, 24);
		`CHK("page start, guarded", 0, n_req)
		cmd(32'hC7, 8);
		`CHK("chip start, guarded", 0, n_req)
		cmd(32'h84BFFE, 25);
		`CHK("page start, late select", 0, n_req)
		cmd(32'h42BFFF, 24);
		`CHK("page start", 1, n_req)
		`CHK("page kind", 3'b001, erase_kind)
		`CHK("page addr", 16'hBFFF, erase_addr)
		status_chk(8'h87);
		// sector erase guard at the half boundary
		do_reset(3'b010);
		cmd(32'h06, 8);
		cmd(32'hD88000, 24);
		`CHK("sector start, guarded", 0, n_req)
		cmd(32'hD87FFF, 24);
		`CHK("sector start", 1, n_req)
		`CHK("sector kind", 3'b010, erase_kind)
		`CHK("sector addr", 16'h7FFF, erase_addr)
		// chip erase
		do_reset(3'b000);
		cmd(32'hC7, 8);
		`CHK("chip start, latch clear", 0, n_req)
		cmd(32'h06, 8);
		cmd(32'hC7, 8);
		`CHK("chip start", 1, n_req)
		`CHK("chip kind", 3'b100, erase_kind)
		status_chk(8'h03);
		// status write runs its whole self-timed cycle
		wp_n = 1'b1;
		do_reset(3'b100);
		cmd(32'h06, 8);
		cmd(32'h018C, 16);
		status_chk(8'h83);
		tick(50010);
		status_chk(8'h8C);
		// deep sleep: framing, ignored commands, wake delay, reset
		do_reset(3'b000);
		cmd(32'h172, 9);
		`CHK("sleep, late select", 1'b0, asleep)
		cmd(32'hB9, 8);
		`CHK("sleep entered", 1'b1, asleep)
		cmd(32'h06, 8);
		`CHK("latch while asleep", 8'h00, protection_status)
		epp_host_model_i.frame(32'hAB0000, 24, 8, rx);
		`CHK("signature", epp_pkg::SIGNATURE, rx)
		tick(900);
		`CHK("wake delay running", 1'b1, asleep)
		tick(200);
		`CHK("awake", 1'b0, asleep)
		cmd(32'hB9, 8);
		do_reset(3'b000);
		`CHK("standby after reset", 1'b0, asleep)
		complete_run();
	end
endmodule
